// *** hw/gdpc_pkg.sv ***
// Constants, field layout and carrier types of the gate driver protection configuration block.
package gdpc_pkg;

    // Bus geometry.
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    // Register byte addresses.
    localparam logic [ADR_W-1:0] CONFIG_ONE_ADR = 8'hac;
    localparam logic [ADR_W-1:0] STATUS_ADR = 8'hb0;

    // Reset value and writable mask of the configuration word.
    localparam logic [DAT_W-1:0] CONFIG_ONE_RST = 32'h00228000;
    localparam logic [DAT_W-1:0] CONFIG_CMD_MASK = 32'hff7fffff;

    // Field positions in the configuration word.
    localparam int SLEW_LSB = 26;
    localparam int CLEAR_BIT = 23;
    localparam int OV_LEVEL_SEL_BIT = 19;
    localparam int OV_ENABLE_BIT = 18;
    localparam int WARN_REPORT_BIT = 16;
    localparam int DEG_LSB = 12;
    localparam int RETRY_BIT = 11;
    localparam int LVL_BIT = 10;
    localparam int MODE_LSB = 8;
    localparam int BEMF_BIT = 7;
    localparam int DEMAG_LS_BIT = 5;
    localparam int DEMAG_HS_BIT = 4;
    localparam int SYNC_REC_BIT = 3;
    localparam int ASYNC_REC_BIT = 2;
    localparam int GAIN_LSB = 0;

    // Field positions in the status word.
    localparam int ST_OC_LATCHED = 0;
    localparam int ST_OC_RETRY = 1;
    localparam int ST_OC_REPORT = 2;
    localparam int ST_OVP_ACTIVE = 3;
    localparam int ST_OTW_SEEN = 4;

    // Sensed input bit positions.
    localparam int SENSE_W = 3;
    localparam int SENSE_OC = 0;
    localparam int SENSE_OV = 1;
    localparam int SENSE_OTW = 2;

    // Clock and timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ = 20000000;
    localparam int DEG_T0_NS = 200;
    localparam int DEG_T1_NS = 600;
    localparam int DEG_T2_NS = 1200;
    localparam int DEG_T3_NS = 1600;
    localparam int DEG_W = 6;
    localparam logic [DEG_W-1:0] DEG_C0 = DEG_W'((DEG_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DEG_W-1:0] DEG_C1 = DEG_W'((DEG_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DEG_W-1:0] DEG_C2 = DEG_W'((DEG_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DEG_W-1:0] DEG_C3 = DEG_W'((DEG_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int RETRY_SHORT_MS = 5;
    localparam int RETRY_LONG_MS = 500;
    localparam int RETRY_W = 24;
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_MS * (CLK_HZ / 1000);
    localparam int RETRY_LONG_CYC = RETRY_LONG_MS * (CLK_HZ / 1000);

    // Overcurrent response modes.
    localparam logic [1:0] MODE_LATCH = 2'h0;
    localparam logic [1:0] MODE_RETRY = 2'h1;
    localparam logic [1:0] MODE_REPORT = 2'h2;
    localparam logic [1:0] MODE_IGNORE = 2'h3;

    // Settings that steer the analog power stage.
    typedef struct packed {
        logic [1:0] slew_rate_sel;
        logic supply_overvoltage_threshold_sel;
        logic supply_overvoltage_enable;
        logic overcurrent_trip_level_sel;
        logic back_emf_comparator_level;
        logic demag_threshold_low_side;
        logic demag_threshold_high_side;
        logic sync_rectification_enable;
        logic async_rectification_enable;
        logic [1:0] current_sense_gain_sel;
    } gdpc_analog_cfg_type;

endpackage

// *** hw/gdpc_input_sync.sv ***
// Two-stage synchroniser for the asynchronous comparator inputs.
`timescale 1ns/1ps
`default_nettype none
module gdpc_input_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [gdpc_pkg::SENSE_W-1:0] async_i,
    output logic [gdpc_pkg::SENSE_W-1:0] sync_o
);
    import gdpc_pkg::*;

    // Each bit passes two flip-flops; only the second one is read.
    for (genvar i = 0; i < SENSE_W; i++) begin : g_bit
        logic meta_r;
        logic stable_r;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta_r <= 1'b0;
                stable_r <= 1'b0;
            end else begin
                meta_r <= async_i[i];
                stable_r <= meta_r;
            end
        end
        assign sync_o[i] = stable_r;
    end
endmodule
`default_nettype wire

// *** hw/gdpc_top.sv ***
// Wishbone register bank and protection sequencing of the gate driver configuration.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gdpc_top #(
    parameter int RETRY_SHORT_CYCLES = gdpc_pkg::RETRY_SHORT_CYC,
    parameter int RETRY_LONG_CYCLES = gdpc_pkg::RETRY_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gdpc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [gdpc_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [gdpc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [gdpc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic overcurrent_raw_i,
    input wire logic overvoltage_raw_i,
    input wire logic overtemp_warning_raw_i,
    output gdpc_pkg::gdpc_analog_cfg_type analog_cfg_o,
    output logic latched_fault_clear_o,
    output logic outputs_disable_o,
    output logic fault_output_pin_n_o
);
    import gdpc_pkg::*;

    // Software owns one configuration word; the protection logic below reads its
    // fields live. A small status word beside it shows the fault flags so that
    // the clear command and the latch, retry and report overcurrent modes can be observed.

    // Retry limits cut to the counter width.
    // The cycle counts default to the real waits; a bench may shorten them.
    localparam logic [RETRY_W-1:0] RETRY_SHORT_LIM = RETRY_W'(RETRY_SHORT_CYCLES);
    localparam logic [RETRY_W-1:0] RETRY_LONG_LIM = RETRY_W'(RETRY_LONG_CYCLES);

    // Configuration word as software sees it.
    logic [DAT_W-1:0] config_r;

    // Bus handshake and decode.
    logic ack_r;
    logic [DAT_W-1:0] rdata_r;
    logic access;
    logic wr_config;
    logic hit_config;
    logic hit_status;

    // Synchronised comparator inputs.
    logic [SENSE_W-1:0] sense_async;
    logic [SENSE_W-1:0] sense_sync;
    logic oc_level;
    logic ov_level;
    logic otw_level;

    // Protection state.
    logic clear_r;
    logic clear_req;
    logic [DEG_W-1:0] deg_cnt_r;
    logic [DEG_W-1:0] deg_limit;
    logic oc_detect;
    logic oc_latched_r;
    logic oc_retry_r;
    logic oc_report_r;
    logic [RETRY_W-1:0] retry_cnt_r;
    logic [RETRY_W-1:0] retry_limit;
    logic ovp_active_r;
    logic otw_seen_r;
    logic otw_report;
    logic disable_r;
    logic fault_n_r;
    logic [1:0] oc_mode;
    logic [DAT_W-1:0] status_word;
    gdpc_analog_cfg_type analog_r;
    gdpc_analog_cfg_type analog_nxt;
    logic [DAT_W-1:0] rdata_nxt;
    logic retry_done;

    // Mode decode and the causes that act on the pins.
    logic oc_act_latch;
    logic oc_act_retry;
    logic oc_act_report;
    logic oc_stop;
    logic fault_any;

    // Bring the comparator levels into the clock domain.
    // Nothing here reads them before the second flip-flop.
    assign sense_async[SENSE_OC] = overcurrent_raw_i;
    assign sense_async[SENSE_OV] = overvoltage_raw_i;
    assign sense_async[SENSE_OTW] = overtemp_warning_raw_i;

    gdpc_input_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(sense_async),
        .sync_o(sense_sync)
    );

    assign oc_level = sense_sync[SENSE_OC];
    assign ov_level = sense_sync[SENSE_OV];
    assign otw_level = sense_sync[SENSE_OTW];

    // A request is served once, in the cycle before ack rises.
    // A strobe held through the ack cycle is not taken twice; a later cycle is.
    assign access = wb_cyc_i && wb_stb_i && !ack_r;
    assign hit_config = (wb_adr_i == CONFIG_ONE_ADR);
    assign hit_status = (wb_adr_i == STATUS_ADR);
    assign wr_config = access && wb_we_i && hit_config;

    // Ack follows every request by one cycle and drops the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    // Byte lanes update the stored word; the clear command bit is never kept.
    // Masking it out of storage means a read never shows a pending clear.
    for (genvar b = 0; b < SEL_W; b++) begin : g_lane
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                config_r[8*b +: 8] <= CONFIG_ONE_RST[8*b +: 8];
            end else if (wr_config && wb_sel_i[b]) begin
                config_r[8*b +: 8] <= wb_dat_i[8*b +: 8] & CONFIG_CMD_MASK[8*b +: 8];
            end
        end
    end

    // A written one in the clear bit becomes a one-cycle command.
    assign clear_req = wr_config && wb_sel_i[CLEAR_BIT/8] && wb_dat_i[CLEAR_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_r <= 1'b0;
        end else begin
            clear_r <= clear_req;
        end
    end

    // Status word built from live protection state.
    always_comb begin
        status_word = '0;
        status_word[ST_OC_LATCHED] = oc_latched_r;
        status_word[ST_OC_RETRY] = oc_retry_r;
        status_word[ST_OC_REPORT] = oc_report_r;
        status_word[ST_OVP_ACTIVE] = ovp_active_r;
        status_word[ST_OTW_SEEN] = otw_seen_r;
    end

    // Read mux; unmapped addresses read zero.
    // Writes to the status address and to unmapped ones change nothing.
    always_comb begin
        rdata_nxt = '0;
        if (hit_config) begin
            rdata_nxt = config_r;
        end else if (hit_status) begin
            rdata_nxt = status_word;
        end
    end

    // Read data is registered with the ack and holds until the next access.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (access) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Analog settings follow the stored fields with no further trigger.
    // The reserved and command bits steer nothing.
    always_comb begin
        analog_nxt.slew_rate_sel = config_r[SLEW_LSB +: 2];
        analog_nxt.supply_overvoltage_threshold_sel = config_r[OV_LEVEL_SEL_BIT];
        analog_nxt.supply_overvoltage_enable = config_r[OV_ENABLE_BIT];
        analog_nxt.overcurrent_trip_level_sel = config_r[LVL_BIT];
        analog_nxt.back_emf_comparator_level = config_r[BEMF_BIT];
        analog_nxt.demag_threshold_low_side = config_r[DEMAG_LS_BIT];
        analog_nxt.demag_threshold_high_side = config_r[DEMAG_HS_BIT];
        analog_nxt.sync_rectification_enable = config_r[SYNC_REC_BIT];
        analog_nxt.async_rectification_enable = config_r[ASYNC_REC_BIT];
        analog_nxt.current_sense_gain_sel = config_r[GAIN_LSB +: 2];
    end

    // Registered copy, so the power stage never sees a decode glitch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_r <= '0;
        end else begin
            analog_r <= analog_nxt;
        end
    end

    // Filter length chosen by the deglitch field.
    always_comb begin
        unique case (config_r[DEG_LSB +: 2])
            2'h0: deg_limit = DEG_C0;
            2'h1: deg_limit = DEG_C1;
            2'h2: deg_limit = DEG_C2;
            2'h3: deg_limit = DEG_C3;
        endcase
    end

    // Overcurrent must stay high for the filter length to count once.
    // The count saturates at the limit, so one long overcurrent detects once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deg_cnt_r <= '0;
        end else if (!oc_level) begin
            deg_cnt_r <= '0;
        end else if (deg_cnt_r < deg_limit) begin
            deg_cnt_r <= deg_cnt_r + 1'b1;
        end
    end

    // One pulse in the cycle the filter fills up.
    assign oc_detect = oc_level && (deg_cnt_r == deg_limit - 1'b1);
    assign oc_mode = config_r[MODE_LSB +: 2];

    // Each mode enables one response; the ignore mode enables none.
    // A mode change leaves flags already set as they are.
    always_comb begin
        oc_act_latch = 1'b0;
        oc_act_retry = 1'b0;
        oc_act_report = 1'b0;
        unique case (oc_mode)
            MODE_LATCH: oc_act_latch = 1'b1;
            MODE_RETRY: oc_act_retry = 1'b1;
            MODE_REPORT: oc_act_report = 1'b1;
            MODE_IGNORE: oc_act_latch = 1'b0;
        endcase
    end

    // Latched fault: set wins over a clear in the same cycle.
    // A detection is never lost to a clear command that falls beside it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_latched_r <= 1'b0;
        end else if (oc_detect && oc_act_latch) begin
            oc_latched_r <= 1'b1;
        end else if (clear_r) begin
            oc_latched_r <= 1'b0;
        end
    end

    // Report-only flag is a latched indication without protective action.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_report_r <= 1'b0;
        end else if (oc_detect && oc_act_report) begin
            oc_report_r <= 1'b1;
        end else if (clear_r) begin
            oc_report_r <= 1'b0;
        end
    end

    // Retry wait chosen by the retry field.
    assign retry_limit = config_r[RETRY_BIT] ? RETRY_LONG_LIM : RETRY_SHORT_LIM;

    // The wait is over in the last cycle of the selected retry time.
    // Reading the limit live lets a new selection take effect at once.
    assign retry_done = oc_retry_r && (retry_cnt_r >= retry_limit - 1'b1);

    // Retrying fault releases itself once the wait has run out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_retry_r <= 1'b0;
        end else if (oc_detect && oc_act_retry) begin
            oc_retry_r <= 1'b1;
        end else if (retry_done) begin
            oc_retry_r <= 1'b0;
        end
    end

    // Retry wait counter runs only while the fault holds the stage off.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retry_cnt_r <= '0;
        end else if (!oc_retry_r || retry_done || (oc_detect && oc_act_retry)) begin
            retry_cnt_r <= '0;
        end else begin
            retry_cnt_r <= retry_cnt_r + 1'b1;
        end
    end

    // Mode 3 leaves every flag untouched, so no path above reacts to it.
    // Supply overvoltage is live while enabled and present.
    // It is not latched: it follows the comparator while enabled.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovp_active_r <= 1'b0;
        end else begin
            ovp_active_r <= config_r[OV_ENABLE_BIT] && ov_level;
        end
    end

    // Over-temperature warning seen at least once, cleared by the command.
    // The set wins over a clear that falls in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            otw_seen_r <= 1'b0;
        end else if (otw_level) begin
            otw_seen_r <= 1'b1;
        end else if (clear_r) begin
            otw_seen_r <= 1'b0;
        end
    end

    // Warning reaches the fault pin only when reporting is enabled.
    assign otw_report = otw_level && config_r[WARN_REPORT_BIT];

    // Causes that stop the power stage and causes that pull the fault pin.
    // Report-only faults and warnings pull the pin but never stop the stage.
    always_comb begin
        oc_stop = oc_latched_r || oc_retry_r;
        fault_any = oc_stop || oc_report_r || ovp_active_r || otw_report;
    end

    // Power stage is shut off by latched, retrying and overvoltage faults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disable_r <= 1'b0;
        end else begin
            disable_r <= oc_stop || ovp_active_r;
        end
    end

    // Fault pin goes low on any reported condition.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_n_r <= 1'b1;
        end else begin
            fault_n_r <= !fault_any;
        end
    end

    // Every output leaves a flip-flop.
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign analog_cfg_o = analog_r;
    assign latched_fault_clear_o = clear_r;
    assign outputs_disable_o = disable_r;
    assign fault_output_pin_n_o = fault_n_r;
endmodule
`default_nettype wire

// *** verif/gdpc_top_sva.sv ***
// Concurrent checks on the ports of the gate driver configuration bank.
`timescale 1ns/1ps
`default_nettype none
module gdpc_top_sva #(
    parameter int RETRY_SHORT_CYCLES = 20,
    parameter int RETRY_LONG_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gdpc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [gdpc_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [gdpc_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [gdpc_pkg::DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic overcurrent_raw_i,
    input wire logic overvoltage_raw_i,
    input wire logic overtemp_warning_raw_i,
    input wire gdpc_pkg::gdpc_analog_cfg_type analog_cfg_o,
    input wire logic latched_fault_clear_o,
    input wire logic outputs_disable_o,
    input wire logic fault_output_pin_n_o
);
    import gdpc_pkg::*;
    logic [11:0] exp_r;
    logic rd_cfg_r;
    // Requests that the bus takes, split by kind.
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic cfg_hit = take && (wb_adr_i == CONFIG_ONE_ADR);
    wire logic wr_cfg = cfg_hit && wb_we_i && (wb_sel_i == 4'hf);
    wire logic clr_req = cfg_hit && wb_we_i && wb_sel_i[2] && wb_dat_i[CLEAR_BIT];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Expected power stage settings and tracking of configuration reads.
    always_ff @(posedge clk_i) begin
        if (wr_cfg) begin
            exp_r <= {wb_dat_i[27:26], wb_dat_i[19:18], wb_dat_i[10], wb_dat_i[7], wb_dat_i[5:0]};
        end
        rd_cfg_r <= cfg_hit && !wb_we_i;
    end
    sequence s_clear;
        clr_req;
    endsequence
    sequence s_pulse;
        latched_fault_clear_o ##1 !latched_fault_clear_o;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (take |=> wb_ack_o)
        else $error("request not acked in one cycle");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_clear_pulse: assert property (s_clear |=> s_pulse)
        else $error("clear write gave no single pulse");
    a_clear_cause: assert property (latched_fault_clear_o |-> $past(clr_req))
        else $error("clear pulse without clear write");
    a_read_no_cmd: assert property (wb_ack_o && rd_cfg_r |-> !wb_dat_o[CLEAR_BIT])
        else $error("clear bit read back as one");
    a_cfg_follow: assert property (wr_cfg |=> ##1 (analog_cfg_o == exp_r))
        else $error("settings do not follow written word");
    a_ovp_trip: assert property ((overvoltage_raw_i && analog_cfg_o[8])[*5]
        |-> outputs_disable_o && !fault_output_pin_n_o)
        else $error("enabled overvoltage did not trip");
    a_reset_state: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o &&
        !latched_fault_clear_o && !outputs_disable_o && fault_output_pin_n_o)
        else $error("outputs not idle after reset");
endmodule
bind gdpc_top gdpc_top_sva #(.RETRY_SHORT_CYCLES(RETRY_SHORT_CYCLES),
    .RETRY_LONG_CYCLES(RETRY_LONG_CYCLES)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .overcurrent_raw_i(overcurrent_raw_i), .overvoltage_raw_i(overvoltage_raw_i),
    .overtemp_warning_raw_i(overtemp_warning_raw_i), .analog_cfg_o(analog_cfg_o),
    .latched_fault_clear_o(latched_fault_clear_o), .outputs_disable_o(outputs_disable_o),
    .fault_output_pin_n_o(fault_output_pin_n_o));
`default_nettype wire

// *** verif/gdpc_test.sv ***
// Self-checking bench for the gate driver configuration bank.
`timescale 1ns/1ps
`default_nettype none
module gdpc_test;
    import gdpc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic oc = 1'b0;
    logic ov = 1'b0;
    logic otw = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    gdpc_analog_cfg_type cfg_o;
    logic clr_o;
    logic dis_o;
    logic pin_n_o;
    logic [31:0] q;
    logic [31:0] v;
    int error_cnt = 0;
    int checks = 0;

    // Retry waits shortened to 20 and 50 cycles.
    gdpc_top #(.RETRY_SHORT_CYCLES(20), .RETRY_LONG_CYCLES(50)) dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .overcurrent_raw_i(oc), .overvoltage_raw_i(ov), .overtemp_warning_raw_i(otw),
        .analog_cfg_o(cfg_o), .latched_fault_clear_o(clr_o), .outputs_disable_o(dis_o),
        .fault_output_pin_n_o(pin_n_o));

    // The 20 MHz clock.
    always #25 clk_i = ~clk_i;

    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One classic bus cycle; read data lands in q.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            chk("ack", 32'h0, 32'h1);
            end_sim();
        end
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Configuration write that keeps reserved bits at their reset values.
    task automatic cfg(input logic [31:0] x);
        wb(1'b1, CONFIG_ONE_ADR, 32'h00228000 | x);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic pulse(input int n);
        @(posedge clk_i);
        oc <= 1'b1;
        repeat (n) @(posedge clk_i);
        oc <= 1'b0;
    endtask

    task automatic outs(input logic d, input logic p);
        chk("disable", {31'h0, dis_o}, {31'h0, d});
        chk("fault_pin_n", {31'h0, pin_n_o}, {31'h0, p});
    endtask

    task automatic st(input logic [31:0] e, input logic d);
        wb(1'b0, STATUS_ADR, 32'h0);
        chk("status", q, e);
        chk("disable", {31'h0, dis_o}, {31'h0, d});
    endtask

    // Hang guard.
    initial begin
        repeat (20000) @(posedge clk_i);
        chk("watchdog", 32'h0, 32'h1);
        end_sim();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CONFIG_ONE_ADR, 32'h0);
        chk("cfg_reset", q, 32'h00228000);
        for (int k = 0; k < 4; k++) begin
            v = 32'h00228000 | (32'(k) << 26) | (32'(k) << 12) | (32'(k) << 8) | 32'(k);
            v = v | (k[0] ? 32'h00090494 : 32'h00040828);
            wb(1'b1, CONFIG_ONE_ADR, v);
            wb(1'b0, CONFIG_ONE_ADR, 32'h0);
            chk("cfg_rw", q, v);
            tick(1);
            chk("analog", {20'h0, cfg_o}, {20'h0, v[27:26], v[19:18], v[10], v[7], v[5:0]});
        end
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", q, 32'h0);
        cfg(32'h0);
        pulse(3);
        tick(8);
        st(32'h0, 1'b0);
        pulse(8);
        tick(30);
        st(32'h1, 1'b1);
        cfg(32'h00800000);
        st(32'h0, 1'b0);
        wb(1'b0, CONFIG_ONE_ADR, 32'h0);
        chk("cfg_cmd", q, 32'h00228000);
        cfg(32'h100);
        pulse(8);
        tick(2);
        outs(1'b1, 1'b0);
        tick(30);
        outs(1'b0, 1'b1);
        cfg(32'h900);
        pulse(8);
        tick(32);
        outs(1'b1, 1'b0);
        tick(30);
        outs(1'b0, 1'b1);
        cfg(32'h3200);
        pulse(20);
        tick(10);
        st(32'h0, 1'b0);
        pulse(40);
        tick(5);
        st(32'h4, 1'b0);
        cfg(32'h00800300);
        pulse(8);
        tick(5);
        st(32'h0, 1'b0);
        @(posedge clk_i);
        ov <= 1'b1;
        tick(6);
        outs(1'b0, 1'b1);
        cfg(32'h000c0000);
        tick(3);
        outs(1'b1, 1'b0);
        cfg(32'h0);
        @(posedge clk_i);
        ov <= 1'b0;
        otw <= 1'b1;
        tick(6);
        outs(1'b0, 1'b1);
        cfg(32'h00010000);
        tick(3);
        outs(1'b0, 1'b0);
        @(posedge clk_i);
        sel <= 4'h1;
        wb(1'b1, CONFIG_ONE_ADR, 32'hffffff03);
        sel <= 4'hf;
        wb(1'b0, CONFIG_ONE_ADR, 32'h0);
        chk("cfg_lane", q, 32'h00238003);
        end_sim();
    end
endmodule
`default_nettype wire
